// ===== hdl/smpc_pkg.sv
// smpc_pkg: constants for the stop-mode power controller
// assumes an axi4-lite register slave with 32-bit data, byte addresses
package smpc_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] PMC2_OFF   = 8'h04;
  localparam logic [7:0] STAT_OFF   = 8'h08;
  localparam logic [7:0] IRQ_ST_OFF = 8'h0C;
  localparam logic [7:0] IRQ_MK_OFF = 8'h10;
  localparam logic [7:0] ID_OFF     = 8'h14;
  // control fields
  localparam int CTRL_DBG_EN_BIT   = 0;
  localparam int CTRL_STOP2_BIT    = 1;
  localparam int CTRL_WAKEPIN_BIT  = 2;
  localparam int CTRL_PWAKE_EN_BIT = 3;
  // power_mode_control_2 fields
  localparam int PMC2_PARTIAL_POWERDOWN_FLAG_BIT     = 3;
  localparam int PMC2_ACK_BIT      = 2;
  // interrupt status fields
  localparam int IRQ_WAKE_BIT      = 0;
  localparam int IRQ_BKGD_BIT      = 1;
  localparam int IRQ_REFUSE_BIT    = 2;
  localparam int IRQ_W             = 3;
  // reset values
  localparam logic [3:0] CTRL_RST  = 4'h0;
  localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;
  // arbitrary identity value, names no part
  localparam logic [31:0] BLOCK_ID = 32'h5350_0001;
  // debug command codes
  localparam logic [1:0] DCMD_STATUS_MEM = 2'h1;
  localparam logic [1:0] DCMD_BACKGROUND = 2'h2;
  localparam logic [1:0] DCMD_OTHER      = 2'h3;
  // debug answer codes
  localparam logic [1:0] DRSP_OK         = 2'h0;
  localparam logic [1:0] DRSP_STOP_ERR   = 2'h1;
  localparam logic [1:0] DRSP_NOT_AVAIL  = 2'h2;
  // power-on restart pulse length
  localparam time POR_PULSE_NS = 64ns;
  localparam int  CLK_NS       = 8;
  localparam int  POR_CYCLES   = (64 + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {SM_RUN, SM_STOP3, SM_STOP2, SM_RESTART, SM_DEBUG} smpc_state_e;
  // axi responses
  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage : smpc_pkg

// ===== hdl/smpc_axil.sv
// smpc_axil: axi4-lite slave front end, one write and one read at a time
// assumes the register file answers reads combinationally from rd_addr
`timescale 1ns/1ps
module smpc_axil
  import smpc_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // register file side
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_ok,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_ok
);
  logic        aw_q, w_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  assign s_awready = !aw_q && !s_bvalid;
  assign s_wready  = !w_q && !s_bvalid;
  assign wr_en     = aw_q && w_q && !s_bvalid;
  assign wr_addr   = awaddr_q;
  assign wr_data   = wdata_q;
  assign wr_strb   = wstrb_q;
  assign rd_addr   = s_araddr;
  assign s_arready = !s_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp  <= AXI_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_wdata;
        wstrb_q <= s_wstrb;
      end
      if (wr_en) begin
        s_bvalid <= 1'b1;
        s_bresp  <= wr_ok ? AXI_OKAY : AXI_SLVERR;
        aw_q     <= 1'b0;
        w_q      <= 1'b0;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= AXI_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata  <= rd_ok ? rd_data : 32'h0000_0000;
      s_rresp  <= rd_ok ? AXI_OKAY : AXI_SLVERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end
endmodule : smpc_axil

// ===== hdl/smpc_top.sv
// smpc_top: stop-mode power controller with debug keep-alive and stop2 recovery
// assumes stop requests, debug commands and wake pins are synchronous to aclk
//
// Notes on behaviour
// - with debug enabled at stop, the debug clock request stays high through stop.
// - with debug enabled at stop, the regulator stays in full regulation.
// - in stop3, a memory-with-status debug command is refused with a stop error code.
// - a background command in stop with debug enabled wakes into active debug mode.
// - in active debug mode every debug command is accepted and answered ok.
// - entering stop2 powers down the core domain but keeps the ram powered.
// - entering stop2 latches the pin controls so pins hold their drive.
// - external reset asserted in stop2 ends stop2.
// - the low-active wake pin ends stop2 only when configured as an input.
// - a wake pin configured as a high driven output never wakes stop2.
// - an enabled periodic wake event ends stop2.
// - wake from stop2 issues a full power-on style restart and vector fetch.
// - low-voltage reset is enabled at the low trip point in every state, not only after wake from stop2.
// - wake from stop2 sets the partial power-down flag.
// - the flag and the pin latch hold until a one is written to the ack bit.
`timescale 1ns/1ps
module smpc_top
  import smpc_pkg::*;
#(
  parameter int PIN_W = 8
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // axi4-lite slave
  input  wire logic [7:0]       s_awaddr,
  input  wire logic             s_awvalid,
  output logic                  s_awready,
  input  wire logic [31:0]      s_wdata,
  input  wire logic [3:0]       s_wstrb,
  input  wire logic             s_wvalid,
  output logic                  s_wready,
  output logic [1:0]            s_bresp,
  output logic                  s_bvalid,
  input  wire logic             s_bready,
  input  wire logic [7:0]       s_araddr,
  input  wire logic             s_arvalid,
  output logic                  s_arready,
  output logic [31:0]           s_rdata,
  output logic [1:0]            s_rresp,
  output logic                  s_rvalid,
  input  wire logic             s_rready,
  // processor side
  input  wire logic             stop_req,
  input  wire logic             ext_reset_n,
  output logic                  cpu_restart,
  output logic                  fetch_reset_vector,
  // debug link commands
  input  wire logic             dbg_cmd_valid,
  input  wire logic [1:0]       dbg_cmd,
  output logic                  dbg_rsp_valid,
  output logic [1:0]            dbg_rsp,
  output logic                  dbg_clk_keep,
  output logic                  active_debug_mode,
  // wake sources
  input  wire logic             external_wake_pin_i,
  input  wire logic             wake_pin_is_output,
  input  wire logic             wake_pin_out_val,
  input  wire logic             periodic_wake_evt,
  // power and low-voltage control
  output logic                  reg_full_on,
  output logic                  core_pwr_on,
  output logic                  ram_pwr_on,
  output logic                  low_voltage_detect_en,
  output logic                  lvd_trip_low,
  // pins
  input  wire logic [PIN_W-1:0] pin_ctl_i,
  output logic [PIN_W-1:0]      pin_ctl_o,
  // interrupt
  output logic                  irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  smpc_state_e           state_q;
  logic [3:0]            ctrl_q;
  logic                  dbg_at_stop_q;
  logic                  partial_powerdown_flag_q;
  logic                  pin_hold_q;
  logic [PIN_W-1:0]      pin_latch_q;
  logic [3:0]            por_cnt_q;
  logic [IRQ_W-1:0]      irq_st_q;
  logic [IRQ_W-1:0]      irq_mk_q;
  logic [IRQ_W-1:0]      irq_set;
  logic                  wr_en, wr_ok, rd_ok;
  logic [7:0]            wr_addr, rd_addr;
  logic [31:0]           wr_data, rd_data;
  logic [3:0]            wr_strb;
  logic                  stop2_wake;
  logic                  pin_wake;
  logic                  ack_wr;

  function automatic logic is_reg(input logic [7:0] a);
    is_reg = (a == CTRL_OFF) || (a == PMC2_OFF) || (a == STAT_OFF) ||
             (a == IRQ_ST_OFF) || (a == IRQ_MK_OFF) || (a == ID_OFF);
  endfunction : is_reg

  smpc_axil u_axil (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .wr_ok     (wr_ok),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .rd_ok     (rd_ok)
  );

  assign wr_ok  = is_reg(wr_addr);
  assign rd_ok  = is_reg(rd_addr);
  assign ack_wr = wr_en && (wr_addr == PMC2_OFF) && wr_strb[0] && wr_data[PMC2_ACK_BIT];

  // ----------------------------------------------------------------
  // wake sources
  // ----------------------------------------------------------------
  // a pin driven as output never wakes, whatever level it drives
  assign pin_wake   = ctrl_q[CTRL_WAKEPIN_BIT] && !wake_pin_is_output
                      && !external_wake_pin_i;
  assign stop2_wake = !ext_reset_n || pin_wake
                      || (ctrl_q[CTRL_PWAKE_EN_BIT] && periodic_wake_evt);

  // ----------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q       <= SM_RUN;
      dbg_at_stop_q <= 1'b0;
      por_cnt_q     <= 4'h0;
    end else begin
      unique case (state_q)
        SM_RUN: begin
          if (stop_req) begin
            dbg_at_stop_q <= ctrl_q[CTRL_DBG_EN_BIT];
            // debug keep-alive forces stop3, the link needs the clocks
            state_q <= (ctrl_q[CTRL_STOP2_BIT] && !ctrl_q[CTRL_DBG_EN_BIT])
                       ? SM_STOP2 : SM_STOP3;
          end
        end
        SM_STOP3: begin
          if (dbg_cmd_valid && dbg_cmd == DCMD_BACKGROUND && dbg_at_stop_q) begin
            state_q <= SM_DEBUG;
          end else if (!ext_reset_n || periodic_wake_evt) begin
            state_q <= SM_RUN;
          end
        end
        SM_STOP2: begin
          if (stop2_wake) begin
            state_q   <= SM_RESTART;
            por_cnt_q <= 4'(POR_CYCLES);
          end
        end
        SM_RESTART: begin
          if (por_cnt_q != 4'h0) begin
            por_cnt_q <= por_cnt_q - 4'h1;
          end else begin
            state_q <= SM_RUN;
          end
        end
        SM_DEBUG: begin
          if (!ext_reset_n) begin
            state_q <= SM_RUN;
          end
        end
      endcase
    end
  end

  assign dbg_clk_keep       = (state_q == SM_STOP3) ? dbg_at_stop_q
                                                    : (state_q != SM_STOP2);
  assign reg_full_on        = (state_q == SM_STOP3) ? dbg_at_stop_q
                                                    : (state_q != SM_STOP2);
  assign core_pwr_on        = (state_q != SM_STOP2);
  assign ram_pwr_on         = 1'b1;
  assign active_debug_mode  = (state_q == SM_DEBUG);
  assign cpu_restart        = (state_q == SM_RESTART);
  assign fetch_reset_vector = (state_q == SM_RESTART) && (por_cnt_q == 4'h0);

  // ----------------------------------------------------------------
  // debug command answers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbg_rsp_valid <= 1'b0;
      dbg_rsp       <= DRSP_OK;
    end else begin
      dbg_rsp_valid <= dbg_cmd_valid && state_q != SM_STOP2;
      if (state_q == SM_DEBUG) begin
        dbg_rsp <= DRSP_OK;
      end else if (state_q == SM_STOP3 && dbg_cmd == DCMD_STATUS_MEM) begin
        dbg_rsp <= DRSP_STOP_ERR;
      end else if (state_q == SM_STOP3 && dbg_cmd != DCMD_BACKGROUND) begin
        dbg_rsp <= DRSP_NOT_AVAIL;
      end else begin
        dbg_rsp <= DRSP_OK;
      end
    end
  end

  // ----------------------------------------------------------------
  // recovery flag and pin latch
  // ----------------------------------------------------------------
  // these survive the restart: only the ack releases them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      partial_powerdown_flag_q     <= 1'b0;
      pin_hold_q <= 1'b0;
    end else if (state_q == SM_STOP2 && stop2_wake) begin
      partial_powerdown_flag_q     <= 1'b1;
      pin_hold_q <= 1'b1;
    end else if (state_q == SM_RUN && stop_req && ctrl_q[CTRL_STOP2_BIT]
                 && !ctrl_q[CTRL_DBG_EN_BIT]) begin
      pin_hold_q <= 1'b1;
    end else if (ack_wr) begin
      partial_powerdown_flag_q     <= 1'b0;
      pin_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_latch_q <= '0;
    end else if (!pin_hold_q) begin
      pin_latch_q <= pin_ctl_i;
    end
  end

  assign pin_ctl_o = pin_hold_q ? pin_latch_q : pin_ctl_i;
  assign low_voltage_detect_en = 1'b1;
  assign lvd_trip_low = 1'b1;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || state_q == SM_RESTART) begin
      ctrl_q   <= CTRL_RST;
      irq_mk_q <= MASK_RST;
    end else if (wr_en && wr_strb[0]) begin
      if (wr_addr == CTRL_OFF) begin
        ctrl_q <= wr_data[3:0];
      end
      if (wr_addr == IRQ_MK_OFF) begin
        irq_mk_q <= wr_data[IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign irq_set[IRQ_WAKE_BIT]   = state_q == SM_RESTART && por_cnt_q == 4'h0;
  assign irq_set[IRQ_BKGD_BIT]   = state_q == SM_STOP3 && dbg_cmd_valid
                                   && dbg_cmd == DCMD_BACKGROUND && dbg_at_stop_q;
  assign irq_set[IRQ_REFUSE_BIT] = state_q == SM_STOP3 && dbg_cmd_valid
                                   && dbg_cmd == DCMD_STATUS_MEM;

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_W; gi++) begin : g_irq
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          irq_st_q[gi] <= 1'b0;
        end else if (irq_set[gi]) begin
          irq_st_q[gi] <= 1'b1;
        end else if (wr_en && wr_strb[0] && wr_addr == IRQ_ST_OFF && wr_data[gi]) begin
          irq_st_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq = |(irq_st_q & irq_mk_q);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      CTRL_OFF:   rd_data[3:0] = ctrl_q;
      PMC2_OFF:   rd_data[PMC2_PARTIAL_POWERDOWN_FLAG_BIT] = partial_powerdown_flag_q;
      STAT_OFF:   rd_data = {26'h0, pin_hold_q, active_debug_mode, dbg_at_stop_q,
                             3'(state_q)};
      IRQ_ST_OFF: rd_data[IRQ_W-1:0] = irq_st_q;
      IRQ_MK_OFF: rd_data[IRQ_W-1:0] = irq_mk_q;
      ID_OFF:     rd_data = BLOCK_ID;
      default:    rd_data = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  dbg_keep_clk_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == SM_STOP3 && dbg_at_stop_q |-> dbg_clk_keep && reg_full_on)
    else $error("debug clocks or regulator dropped in stop");
  reg_full_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == SM_RUN && stop_req && ctrl_q[CTRL_DBG_EN_BIT] |=> reg_full_on)
    else $error("regulator left full regulation");
  stop_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == SM_STOP3 && dbg_cmd_valid && dbg_cmd == DCMD_STATUS_MEM
    |=> dbg_rsp_valid && dbg_rsp == DRSP_STOP_ERR)
    else $error("stop memory access not refused");
  bkgd_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == SM_STOP3 && dbg_at_stop_q && dbg_cmd_valid && dbg_cmd == DCMD_BACKGROUND
    |=> active_debug_mode)
    else $error("background command did not wake");
  dbg_full_a: assert property (@(posedge aclk) disable iff (!aresetn)
    active_debug_mode && dbg_cmd_valid |=> dbg_rsp_valid && dbg_rsp == DRSP_OK)
    else $error("debug command refused in debug mode");
  stop2_pwr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == SM_STOP2 |-> !core_pwr_on && ram_pwr_on && pin_hold_q)
    else $error("stop2 power or pin hold wrong");
  pin_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_hold_q && $past(pin_hold_q) |-> $stable(pin_ctl_o))
    else $error("held pin changed");
  wake_src_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == SM_STOP2 && !ext_reset_n |=> cpu_restart)
    else $error("reset did not end stop2");
  out_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == SM_STOP2 && ext_reset_n && wake_pin_is_output && !periodic_wake_evt
    |=> state_q == SM_STOP2)
    else $error("output wake pin woke stop2");
  restart_seq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == SM_STOP2 && stop2_wake
    |=> cpu_restart [*8] ##1 (cpu_restart && fetch_reset_vector) ##1 !cpu_restart)
    else $error("restart pulse length wrong");
  partial_powerdown_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == SM_STOP2 && stop2_wake |=> partial_powerdown_flag_q ##1 (ctrl_q == CTRL_RST) ##8 partial_powerdown_flag_q)
    else $error("recovery flag not set");
  ack_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    partial_powerdown_flag_q && !ack_wr && !(state_q == SM_STOP2) |=> partial_powerdown_flag_q)
    else $error("recovery flag dropped without ack");
endmodule : smpc_top

// ===== tb/smpc_dbg_host.sv
// smpc_dbg_host: behavioural debug host on the command lines of the controller
// assumes commands and answers are synchronous to aclk
`timescale 1ns/1ps
module smpc_dbg_host
  import smpc_pkg::*;
(
  // clock
  input  wire logic       aclk,
  // debug link
  output logic            dbg_cmd_valid,
  output logic [1:0]      dbg_cmd,
  input  wire logic       dbg_rsp_valid,
  input  wire logic [1:0] dbg_rsp
);
  initial begin
    dbg_cmd_valid = 1'b0;
    dbg_cmd       = 2'h0;
  end
  // any command, background included, may be sent while stopped
  task automatic send(input logic [1:0] cmd, output logic [1:0] rsp, output logic got);
    dbg_cmd_valid <= 1'b1;
    dbg_cmd       <= cmd;
    @(posedge aclk);
    dbg_cmd_valid <= 1'b0;
    // idle lines carry the inverse so a stale code is never mistaken for a command
    dbg_cmd       <= ~cmd;
    @(posedge aclk);
    got = dbg_rsp_valid;
    rsp = dbg_rsp;
  endtask : send
endmodule : smpc_dbg_host

// ===== tb/smpc_top_test.sv
// smpc_top_test: self-checking bench for the stop-mode power controller
// assumes smpc_dbg_host plays the debug host; wake sources are driven here
`timescale 1ns/1ps
module smpc_top_test;
  import smpc_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_awaddr = '0, s_araddr = '0, pin_i = 8'hA5, pin_o;
  logic [31:0] s_wdata = '0, s_rdata;
  logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp, dbg_cmd, dbg_rsp;
  logic        stop_req = 0, ext_reset_n = 1, wake_n = 1, wake_out = 0, pwake = 0;
  logic        cpu_restart, fetch_rv, dbg_cmd_valid, dbg_rsp_valid, clk_keep, adm;
  logic        reg_on, core_on, ram_on, lvd_en, lvd_low, irq;
  int          err_count = 0, cmp_count = 0, cycles = 0;

  smpc_top DUT (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hF), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .stop_req(stop_req),
    .ext_reset_n(ext_reset_n), .cpu_restart(cpu_restart), .fetch_reset_vector(fetch_rv),
    .dbg_cmd_valid(dbg_cmd_valid), .dbg_cmd(dbg_cmd), .dbg_rsp_valid(dbg_rsp_valid),
    .dbg_rsp(dbg_rsp), .dbg_clk_keep(clk_keep), .active_debug_mode(adm),
    .external_wake_pin_i(wake_n), .wake_pin_is_output(wake_out),
    .wake_pin_out_val(wake_out), .periodic_wake_evt(pwake), .reg_full_on(reg_on),
    .core_pwr_on(core_on), .ram_pwr_on(ram_on), .low_voltage_detect_en(lvd_en),
    .lvd_trip_low(lvd_low), .pin_ctl_i(pin_i), .pin_ctl_o(pin_o), .irq(irq));
  smpc_dbg_host DBG (.aclk(aclk), .dbg_cmd_valid(dbg_cmd_valid), .dbg_cmd(dbg_cmd),
    .dbg_rsp_valid(dbg_rsp_valid), .dbg_rsp(dbg_rsp));

  always #4 aclk = ~aclk;
  // the whole run needs well under 2000 cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    while (s_awvalid || s_wvalid) begin
      @(posedge aclk);
      if (s_awready === 1'b1) s_awvalid <= 1'b0;
      if (s_wready === 1'b1) s_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (s_bvalid !== 1'b1);
    s_bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    do @(posedge aclk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    while (s_rvalid !== 1'b1) @(posedge aclk);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd

  task automatic pulse_stop();
    stop_req <= 1'b1;
    @(posedge aclk);
    stop_req <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : pulse_stop

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(CTRL_OFF, d, r);
    chk("ctrl reset", d, 32'h0000_0000);
    axi_rd(8'h40, d, r);
    chk("unmapped resp", {30'h0, r}, {30'h0, AXI_SLVERR});
  endtask : t_regs

  // stop3 with debug enabled or not, refused memory access, background wake
  task automatic t_stop3(input logic en);
    logic [1:0] r;
    logic       g;
    axi_wr(CTRL_OFF, {31'h0, en});
    axi_wr(IRQ_MK_OFF, 32'h0000_0002);
    pulse_stop();
    chk("clk keep", clk_keep, en);
    chk("regulator", reg_on, en);
    DBG.send(DCMD_STATUS_MEM, r, g);
    chk("stop mem rsp", {g, r}, {1'b1, DRSP_STOP_ERR});
    chk("clk keep held", clk_keep, en);
    DBG.send(DCMD_BACKGROUND, r, g);
    for (int i = 0; i < 8 && adm !== 1'b1; i++) @(posedge aclk);
    chk("debug mode", adm, en);
    chk("irq raised", irq, en);
    axi_wr(IRQ_ST_OFF, 32'h0000_0002);
    chk("irq cleared", irq, 1'b0);
    if (en) begin
      DBG.send(DCMD_OTHER, r, g);
      chk("debug other", {g, r}, {1'b1, DRSP_OK});
      DBG.send(DCMD_STATUS_MEM, r, g);
      chk("debug mem", {g, r}, {1'b1, DRSP_OK});
    end
    ext_reset_n <= 1'b0;
    @(posedge aclk);
    ext_reset_n <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask : t_stop3

  // stop2 with wake by reset (0), pin (1), counter (2), pin as high output (3)
  task automatic t_stop2(input int src);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    n = 0;
    pin_i    <= 8'hA5;
    wake_out <= (src == 3);
    wake_n   <= 1'b1;
    axi_wr(CTRL_OFF, 32'h0000_000E);
    pulse_stop();
    chk("core power", core_on, 1'b0);
    chk("ram power", ram_on, 1'b1);
    pin_i <= 8'h3C;
    repeat (2) @(posedge aclk);
    chk("pins held", pin_o, 8'hA5);
    if (src == 3) begin
      wake_n <= 1'b0;
      repeat (20) @(posedge aclk);
      chk("output pin no wake", core_on, 1'b0);
    end
    if (src == 0) ext_reset_n <= 1'b0;
    if (src == 1) wake_n <= 1'b0;
    if (src >= 2) pwake <= 1'b1;
    @(posedge aclk);
    ext_reset_n <= 1'b1;
    wake_n      <= 1'b1;
    pwake       <= 1'b0;
    do begin
      @(posedge aclk);
      if (cpu_restart === 1'b1) n++;
    end while (fetch_rv !== 1'b1);
    chk("restart cycles", n, 9);
    chk("lvd enable", {lvd_en, lvd_low}, 2'b11);
    repeat (4) @(posedge aclk);
    axi_rd(CTRL_OFF, d, r);
    chk("ctrl after wake", d, 32'h0000_0000);
    axi_rd(PMC2_OFF, d, r);
    chk("flag set", d[PMC2_PARTIAL_POWERDOWN_FLAG_BIT], 1'b1);
    axi_wr(PMC2_OFF, 32'h0000_0000);
    axi_rd(PMC2_OFF, d, r);
    chk("flag kept", d[PMC2_PARTIAL_POWERDOWN_FLAG_BIT], 1'b1);
    chk("pins kept", pin_o, 8'hA5);
    axi_wr(PMC2_OFF, 32'h0000_0001 << PMC2_ACK_BIT);
    axi_rd(PMC2_OFF, d, r);
    chk("flag released", d[PMC2_PARTIAL_POWERDOWN_FLAG_BIT], 1'b0);
    chk("pins released", pin_o, 8'h3C);
  endtask : t_stop2

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_stop3(1'b1);
    t_stop3(1'b0);
    for (int s = 0; s < 4; s++) t_stop2(s);
    tally_and_finish();
  end
endmodule : smpc_top_test
